// ==== common/ecac_regs.svh ====
// Behaviour
// RULE1 - reset returns the card to unconfigured, dropping base address and shut-up.
// RULE2 - chain output is negated at once when reset arrives.
// RULE3 - unconfigured with chain input negated: drive nothing, answer no cycle.
// RULE4 - local memory refresh may continue through reset; local work resumes after.
// RULE5 - unconfigured card with chain input asserted answers configuration space accesses.
// RULE6 - read-only descriptor registers from block base, then write-only registers.
// RULE7 - chain output asserts on final base address write or any shut-up write.
// RULE8 - legacy space is 64K at 00E8xxxx, reached with 16-bit cycles.
// RULE9 - 32-bit space is 64K at FF00xxxx; decode only top address byte.
// RULE10 - card configures in exactly one space, never both at once.
// RULE11 - register reads return meaningful data only in top four data bits.
// RULE12 - write-only registers accept nybble, byte or word writes alike.
// RULE13 - each register is eight bits from two nybbles at paired addresses.
// RULE14 - every read-only register except 00 reads back complemented.
// RULE15 - pair is offset and offset+2 legacy, offset and offset+100 wide.
// RULE16 - register 3C is logically zero, so both nybbles read all ones.
// RULE17 - shared open-collector lines are only pulled low, never driven high.
// RULE18 - register 00 bits 7:6 hold board type: 10 wide card, 11 legacy.
// RULE19 - decode config space only unconfigured with chain input asserted.
`ifndef ECAC_REGS_SVH
`define ECAC_REGS_SVH
`define ECAC_LEG_BASE 8'hE8
`define ECAC_LEG_HI 8'h00
`define ECAC_WIDE_BASE 8'hFF
`define ECAC_WIDE_HI_BYTE 8'h00
`define ECAC_REG_TYPE 6'h00
`define ECAC_REG_PROD 6'h01
`define ECAC_REG_FLAGS 6'h02
`define ECAC_REG_MFG_HI 6'h04
`define ECAC_REG_MFG_LO 6'h05
`define ECAC_REG_ZERO 6'h0F
`define ECAC_REG_BASE_WIDE 6'h11
`define ECAC_REG_BASE_LEG 6'h12
`define ECAC_REG_SHUTUP 6'h13
`define ECAC_TYPE_WIDE 2'h2
`define ECAC_TYPE_LEG 2'h3
`define ECAC_LEG_PAIR_BIT 1
`define ECAC_WIDE_PAIR_BIT 8
`define ECAC_REG_RSVD_0C 6'h03
`define ECAC_REG_SER_0 6'h06
`define ECAC_REG_SER_1 6'h07
`define ECAC_REG_SER_2 6'h08
`define ECAC_REG_SER_3 6'h09
`define ECAC_REG_VEC_HI 6'h0A
`define ECAC_REG_VEC_LO 6'h0B
`define ECAC_REG_RSVD_30 6'h0C
`define ECAC_REG_RSVD_34 6'h0D
`define ECAC_REG_RSVD_38 6'h0E
`define ECAC_REG_WO_40 6'h10
`define ECAC_LOGIC_ZERO 8'h00
`endif

// ==== common/ecac_pkg.sv ====
package ecac_pkg;
  typedef enum logic [1:0] {
    ECAC_UNCONF = 2'h0,
    ECAC_CONFIGURED = 2'h1,
    ECAC_SHUTUP = 2'h2
  } ecac_state_e;
  typedef struct packed {
    ecac_state_e state;
    logic [1:0] cin_sync;
    logic chain_out;
    logic [7:0] base_hi;
    logic [3:0] base_lo_nyb;
    logic [3:0] rd_data;
    logic rd_oe;
    logic ack;
  } ecac_state_s;
endpackage

// ==== logic/ecac_card.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ecac_regs.svh"
module ecac_card
  import ecac_pkg::*;
#(
  parameter logic WIDE_SPACE = 1'b1,
  parameter logic [7:0] PRODUCT_ID = 8'h01,
  parameter logic [15:0] MAKER_ID = 16'h1234,
  parameter logic [7:0] FLAGS_VAL = 8'h10,
  parameter logic [5:0] SIZE_BITS = 6'h00
)
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic config_chain_in_n_i,
  input wire logic [31:0] addr_i,
  input wire logic cycle_i,
  input wire logic read_i,
  input wire logic [3:0] wdata_i,
  output logic [3:0] rdata_o,
  output logic rdata_oe_o,
  output logic config_chain_out_n_o,
  output logic transfer_ack_line_o,
  output logic transfer_ack_line_oe_o,
  output logic configured_o,
  output logic [7:0] base_addr_o
);
  ecac_state_s cur_r;
  ecac_state_s cur_nxt;
  logic chain_in;
  logic in_space;
  logic [5:0] reg_idx;
  logic hi_nyb;
  logic [7:0] logical;
  logic [7:0] shown;
  logic [3:0] nyb;
  logic wide_hit;
  logic wide_hi;
  logic leg_hit;
  logic leg_hi;
  logic take;
  logic take_rd;
  logic take_wr;
  logic wr_base;
  logic wr_base_first;
  logic wr_base_last;
  logic wr_shut;
  logic [7:0] base_full;

  ecac_space_dec
  #(
    .TOP_BYTE(`ECAC_WIDE_BASE),
    .NEXT_BYTE(`ECAC_WIDE_HI_BYTE),
    .USE_NEXT(1'b0),
    .PAIR_BIT(`ECAC_WIDE_PAIR_BIT)
  )
  ecac_space_dec_wide_inst
  (
    .addr_i(addr_i),
    .hit_o(wide_hit),
    .hi_nyb_o(wide_hi)
  );

  ecac_space_dec
  #(
    .TOP_BYTE(`ECAC_LEG_HI),
    .NEXT_BYTE(`ECAC_LEG_BASE),
    .USE_NEXT(1'b1),
    .PAIR_BIT(`ECAC_LEG_PAIR_BIT)
  )
  ecac_space_dec_leg_inst
  (
    .addr_i(addr_i),
    .hit_o(leg_hit),
    .hi_nyb_o(leg_hi)
  );

  assign chain_in = cur_r.cin_sync[1];

  always_comb
  begin
    // one space only, fixed at build time
    if (WIDE_SPACE) // RULE10
    begin
      in_space = wide_hit; // RULE9
      hi_nyb = wide_hi;
    end
    else
    begin
      in_space = leg_hit; // RULE8
      hi_nyb = leg_hi;
    end
    reg_idx = addr_i[7:2];
    // unlisted, reserved and write-only registers read as logical zero
    case (reg_idx)
      `ECAC_REG_TYPE:
      begin
        logical = {WIDE_SPACE ? `ECAC_TYPE_WIDE : `ECAC_TYPE_LEG,
          SIZE_BITS}; // RULE18
      end
      `ECAC_REG_PROD:
      begin
        logical = PRODUCT_ID;
      end
      `ECAC_REG_FLAGS:
      begin
        logical = FLAGS_VAL;
      end
      `ECAC_REG_RSVD_0C:
      begin
        logical = `ECAC_LOGIC_ZERO;
      end
      `ECAC_REG_MFG_HI:
      begin
        logical = MAKER_ID[15:8];
      end
      `ECAC_REG_MFG_LO:
      begin
        logical = MAKER_ID[7:0];
      end
      // no serial number on this card
      `ECAC_REG_SER_0:
      begin
        logical = `ECAC_LOGIC_ZERO;
      end
      `ECAC_REG_SER_1:
      begin
        logical = `ECAC_LOGIC_ZERO;
      end
      `ECAC_REG_SER_2:
      begin
        logical = `ECAC_LOGIC_ZERO;
      end
      `ECAC_REG_SER_3:
      begin
        logical = `ECAC_LOGIC_ZERO;
      end
      // no boot code, so the vector is left empty
      `ECAC_REG_VEC_HI:
      begin
        logical = `ECAC_LOGIC_ZERO;
      end
      `ECAC_REG_VEC_LO:
      begin
        logical = `ECAC_LOGIC_ZERO;
      end
      `ECAC_REG_RSVD_30:
      begin
        logical = `ECAC_LOGIC_ZERO;
      end
      `ECAC_REG_RSVD_34:
      begin
        logical = `ECAC_LOGIC_ZERO;
      end
      `ECAC_REG_RSVD_38:
      begin
        logical = `ECAC_LOGIC_ZERO;
      end
      `ECAC_REG_ZERO:
      begin
        logical = `ECAC_LOGIC_ZERO; // RULE16
      end
      `ECAC_REG_WO_40:
      begin
        logical = `ECAC_LOGIC_ZERO; // RULE6
      end
      `ECAC_REG_BASE_WIDE:
      begin
        logical = `ECAC_LOGIC_ZERO; // RULE6
      end
      `ECAC_REG_BASE_LEG:
      begin
        logical = `ECAC_LOGIC_ZERO; // RULE6
      end
      `ECAC_REG_SHUTUP:
      begin
        logical = `ECAC_LOGIC_ZERO; // RULE6
      end
      default:
      begin
        logical = `ECAC_LOGIC_ZERO; // RULE6
      end
    endcase
  end

  // only register 00 shows its true value
  always_comb
  begin
    if (reg_idx == `ECAC_REG_TYPE)
    begin
      shown = logical;
    end
    else
    begin
      shown = ~logical; // RULE14
    end
    if (hi_nyb)
    begin
      nyb = shown[7:4]; // RULE13
    end
    else
    begin
      nyb = shown[3:0]; // RULE13
    end
  end

  // silent unless selected by the chain and still unconfigured
  always_comb
  begin
    take = 1'b0;
    if (cur_r.state == ECAC_UNCONF) // RULE19
    begin
      if (chain_in && cycle_i && in_space) // RULE3 RULE5
      begin
        take = 1'b1;
      end
    end
    take_rd = take && read_i;
    take_wr = take && !read_i;
    wr_base = 1'b0;
    wr_shut = 1'b0;
    if (take_wr)
    begin
      // a nybble lane is all we need; wider writes land the same
      case (reg_idx) // RULE12
        `ECAC_REG_BASE_WIDE:
        begin
          wr_base = WIDE_SPACE;
        end
        `ECAC_REG_BASE_LEG:
        begin
          wr_base = !WIDE_SPACE;
        end
        `ECAC_REG_SHUTUP:
        begin
          wr_shut = 1'b1;
        end
        default:
        begin
          wr_base = 1'b0;
        end
      endcase
    end
    // low nybble first; the high one completes the address in both spaces
    wr_base_first = wr_base && !hi_nyb;
    wr_base_last = wr_base && hi_nyb;
    base_full = {wdata_i, cur_r.base_lo_nyb};
  end

  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.cin_sync = {cur_r.cin_sync[0], ~config_chain_in_n_i};
    cur_nxt.ack = take; // RULE5
    cur_nxt.rd_oe = take_rd;
    if (take_rd)
    begin
      cur_nxt.rd_data = nyb; // RULE11
    end
    if (wr_base_first)
    begin
      cur_nxt.base_lo_nyb = wdata_i;
    end
    if (wr_base_last)
    begin
      cur_nxt.base_hi = base_full;
      cur_nxt.state = ECAC_CONFIGURED;
      cur_nxt.chain_out = 1'b1; // RULE7
    end
    if (wr_shut)
    begin
      cur_nxt.state = ECAC_SHUTUP;
      cur_nxt.chain_out = 1'b1; // RULE7
    end
  end

  // async reset: chain out drops at once, config forgotten
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cur_r <= '0; // RULE1 RULE2
    end
    else if (clk_en_i) // RULE4
    begin
      cur_r <= cur_nxt;
    end
  end

  assign rdata_o = cur_r.rd_data;
  assign rdata_oe_o = cur_r.rd_oe;
  assign config_chain_out_n_o = ~cur_r.chain_out;
  // open collector: level held low, enable only when pulling
  assign transfer_ack_line_o = 1'b0; // RULE17
  assign transfer_ack_line_oe_o = cur_r.ack; // RULE17
  assign configured_o = (cur_r.state == ECAC_CONFIGURED);
  assign base_addr_o = cur_r.base_hi;
endmodule

// one copy per space keeps both decodes alike
module ecac_space_dec
#(
  parameter logic [7:0] TOP_BYTE = 8'h00,
  parameter logic [7:0] NEXT_BYTE = 8'h00,
  parameter logic USE_NEXT = 1'b0,
  parameter int PAIR_BIT = 1
)
(
  input wire logic [31:0] addr_i,
  output logic hit_o,
  output logic hi_nyb_o
);
  always_comb
  begin
    // wide space needs only the top byte, cheaper compare
    if (USE_NEXT)
    begin
      hit_o = (addr_i[31:24] == TOP_BYTE)
        && (addr_i[23:16] == NEXT_BYTE);
    end
    else
    begin
      hit_o = (addr_i[31:24] == TOP_BYTE);
    end
    // first address of the pair carries the high nybble
    hi_nyb_o = ~addr_i[PAIR_BIT]; // RULE15
  end
endmodule
`default_nettype wire

// ==== verif/ecac_bus_mdl.sv ====
`timescale 1ns/100ps
`default_nettype none
module ecac_bus_mdl (
  input wire logic ack_oe_i,
  output logic ack_n_o
);
  // released line floats up to the backplane resistor level
  assign ack_n_o = !ack_oe_i;
endmodule
`default_nettype wire

// ==== verif/ecac_card_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module ecac_card_asserts (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic config_chain_in_n_i,
  input wire logic [31:0] addr_i,
  input wire logic read_i,
  input wire logic [3:0] rdata_o,
  input wire logic rdata_oe_o,
  input wire logic config_chain_out_n_o,
  input wire logic transfer_ack_line_o,
  input wire logic transfer_ack_line_oe_o,
  input wire logic configured_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_ack_low: assert property (transfer_ack_line_o == 1'b0)
    else $error("ack driven high");
  chk_rd_space: assert property (rdata_oe_o |-> $past(read_i) &&
    $past(addr_i[31:24]) == 8'hFF && transfer_ack_line_oe_o)
    else $error("read answered outside space");
  chk_reg_type: assert property (rdata_oe_o &&
    $past(addr_i[15:0]) == 16'h0000 |-> rdata_o == 4'h8)
    else $error("bad type nybble");
  chk_zero_reg: assert property (rdata_oe_o &&
    $past(addr_i[7:0]) == 8'h3C |-> rdata_o == 4'hF)
    else $error("zero reg not all ones");
  // depths 2..4 cover the two-flop chain sync
  chk_quiet_chain: assert property ($past(config_chain_in_n_i, 2) &&
    $past(config_chain_in_n_i, 3) && $past(config_chain_in_n_i, 4) &&
    !configured_o |-> !transfer_ack_line_oe_o)
    else $error("answered with chain negated");
  chk_cfg_quiet: assert property ($past(configured_o) |->
    !transfer_ack_line_oe_o)
    else $error("answered once configured");
  chk_chain_cfg: assert property ($rose(configured_o) |->
    ##[0:1] !config_chain_out_n_o)
    else $error("chain out not asserted");
  chk_reset_out: assert property (disable iff (1'b0) !reset_n_i |->
    config_chain_out_n_o && !configured_o)
    else $error("reset state wrong");
  cover property (rdata_oe_o);
  cover property ($rose(configured_o));
  cover property ($fell(config_chain_out_n_o));
endmodule
bind ecac_card ecac_card_asserts ecac_card_asserts_inst (.*);
`default_nettype wire

// ==== verif/ecac_card_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module ecac_card_tb;
  logic clk = 0, rst_n = 1, cin_n = 1, cyc = 0, rd = 0;
  logic [31:0] adr = 0;
  logic [3:0] wd = 0, rdat;
  logic oe, cout_n, ack, ack_oe, cfgd, ack_n;
  logic [7:0] base;
  int err_count = 0, n_tests = 0;
  always #10 clk = !clk;
  ecac_card ecac_card_inst (.sys_clk_i(clk), .reset_n_i(rst_n),
    .clk_en_i(1'b1), .config_chain_in_n_i(cin_n), .addr_i(adr),
    .cycle_i(cyc), .read_i(rd), .wdata_i(wd), .rdata_o(rdat),
    .rdata_oe_o(oe), .config_chain_out_n_o(cout_n),
    .transfer_ack_line_o(ack), .transfer_ack_line_oe_o(ack_oe),
    .configured_o(cfgd), .base_addr_o(base));
  ecac_bus_mdl ecac_bus_mdl_inst (.ack_oe_i(ack_oe), .ack_n_o(ack_n));
  task automatic chk(string s, logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic xf(logic [31:0] a, logic r, logic [3:0] w, logic ex,
    logic [3:0] d);
    @(negedge clk);
    {adr, rd, wd, cyc} = {a, r, w, 1'b1};
    for (int i = 0; i < 4 && ack_n !== 1'b0; i++)
      @(negedge clk);
    cyc = 0;
    chk("ack", !ack_n, ex);
    if (ex && ack_n !== 1'b0)
      end_of_test();
    if (r && ex)
      chk("rdata", oe ? rdat : 4'hX, d);
  endtask
  task automatic rst();
    @(negedge clk);
    rst_n = 0;
    repeat (6) @(negedge clk);
    chk("cout", cout_n, 1);
    chk("cfg", {base, cfgd}, 0);
    rst_n = 1;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_rom();
    xf(32'hFF000000, 1, 0, 0, 0);
    cin_n = 0;
    repeat (3) @(negedge clk);
    xf(32'hFF000000, 1, 0, 1, 4'h8);
    xf(32'hFF000100, 1, 0, 1, 4'h0);
    xf(32'hFF000104, 1, 0, 1, 4'hE);
    xf(32'hFF00003C, 1, 0, 1, 4'hF);
    xf(32'hFF00013C, 1, 0, 1, 4'hF);
    xf(32'h00E80000, 1, 0, 0, 0);
  endtask
  task automatic t_cfg();
    xf(32'hFF000144, 0, 4'h5, 1, 0);
    chk("cout", cout_n, 1);
    xf(32'hFF000044, 0, 4'hA, 1, 0);
    chk("cout", {base, cout_n, cfgd}, 10'h295);
    xf(32'hFF000000, 1, 0, 0, 0);
  endtask
  task automatic t_shut();
    rst();
    xf(32'hFF00004C, 0, 4'h0, 1, 0);
    chk("shut", {cout_n, cfgd}, 0);
    xf(32'hFF000000, 1, 0, 0, 0);
  endtask
  initial
  begin
    rst();
    t_rom();
    t_cfg();
    t_shut();
    end_of_test();
  end
endmodule
`default_nettype wire
